// >>> rtl/bst_defs.vh
`ifndef BST_DEFS_VH
`define BST_DEFS_VH

// ****************************************************************
// tap controller state codes
// ****************************************************************
`define BST_ST_RESET 4'h0
`define BST_ST_IDLE 4'h1
`define BST_ST_SEL_DR 4'h2
`define BST_ST_CAP_DR 4'h3
`define BST_ST_SH_DR 4'h4
`define BST_ST_EX1_DR 4'h5
`define BST_ST_PAU_DR 4'h6
`define BST_ST_EX2_DR 4'h7
`define BST_ST_UPD_DR 4'h8
`define BST_ST_SEL_IR 4'h9
`define BST_ST_CAP_IR 4'ha
`define BST_ST_SH_IR 4'hb
`define BST_ST_EX1_IR 4'hc
`define BST_ST_PAU_IR 4'hd
`define BST_ST_EX2_IR 4'he
`define BST_ST_UPD_IR 4'hf

// ****************************************************************
// instruction codes and capture pattern
// ****************************************************************
`define BST_IR_W 5
`define BST_OP_EXTEST 5'h00
`define BST_OP_SAMPLE 5'h01
`define BST_OP_CLAMP 5'h04
`define BST_OP_HIGHZ 5'h05
`define BST_OP_IDCODE 5'h0c
`define BST_OP_BYPASS 5'h1f
`define BST_IR_CAPTURE 5'h01

// ****************************************************************
// data register selection codes
// ****************************************************************
`define BST_SEL_BYPASS 2'h0
`define BST_SEL_BOUNDARY 2'h1
`define BST_SEL_IDENT 2'h2

// ****************************************************************
// identification register layout
// ****************************************************************
`define BST_ID_W 32
`define BST_ID_FIXED 1'h1
`define BST_ID_VER_W 4
`define BST_ID_PART_W 16
`define BST_ID_MFR_W 11

// ****************************************************************
// output buffer sizing
// ****************************************************************
`define BST_FIFO_DEPTH 16

`endif

// >>> rtl/bst_tap.v
`timescale 1ns/1ps
`default_nettype none
`include "bst_defs.vh"

// ****************************************************************
// output bit buffer
// ****************************************************************
module bst_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = `BST_FIFO_DEPTH,
  parameter AW = 4
) (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  // fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // storage, no reset needed
  reg [AW-1:0] wr_q; // write pointer
  reg [AW-1:0] rd_q; // read pointer
  reg [AW:0] cnt_q; // words held
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  // full and empty come straight from the count
  assign in_ready_o = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o = mem_q[rd_q];

  // storage write
  always @(posedge sys_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // pointers wrap at depth so depth need not be a power of two
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // bst_fifo

// ****************************************************************
// test access port with boundary scan
// ****************************************************************
module bst_tap #(
  parameter NUM_IN = 3,
  parameter NUM_OUT = 2,
  parameter NUM_IO = 4,
  parameter [`BST_ID_VER_W-1:0] ID_VERSION = 4'h3, // arbitrary value
  parameter [`BST_ID_PART_W-1:0] ID_PART = 16'h5a5a, // arbitrary value
  parameter [`BST_ID_MFR_W-1:0] ID_MFR = 11'h2a6 // arbitrary value
) (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  // test port pins
  input wire tck_i,
  input wire tms_i,
  input wire tdi_i,
  input wire trst_n_i,
  output wire tdo_o,
  output wire tdo_oe_o,
  // core side
  input wire [NUM_OUT-1:0] core_out_i,
  input wire [NUM_IO-1:0] core_io_out_i,
  input wire [NUM_IO-1:0] core_io_oe_i,
  output wire [NUM_IN-1:0] core_in_o,
  output wire [NUM_IO-1:0] core_io_in_o,
  // pad side
  input wire [NUM_IN-1:0] pad_in_i,
  output wire [NUM_OUT-1:0] pad_out_o,
  output wire [NUM_OUT-1:0] pad_out_oe_o,
  input wire [NUM_IO-1:0] pad_io_i,
  output wire [NUM_IO-1:0] pad_io_o,
  output wire [NUM_IO-1:0] pad_io_oe_o,
  // status
  output wire [3:0] tap_state_o,
  output wire [`BST_IR_W-1:0] instr_o
);
  // chain layout: inputs, outputs, bidir data, bidir controls
  localparam OFS_OUT = NUM_IN;
  localparam OFS_IO = NUM_IN + NUM_OUT;
  localparam OFS_CTL = NUM_IN + NUM_OUT + NUM_IO;
  localparam CHAIN = NUM_IN + NUM_OUT + 2 * NUM_IO;
  localparam [`BST_ID_W-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MFR, `BST_ID_FIXED};

  // ****************************************************************
  // decoding helpers
  // ****************************************************************
  // instruction to data register; unknown codes fall to bypass
  function [1:0] dr_sel;
    input [`BST_IR_W-1:0] ir;
    begin
      case (ir)
        `BST_OP_EXTEST: dr_sel = `BST_SEL_BOUNDARY;
        `BST_OP_SAMPLE: dr_sel = `BST_SEL_BOUNDARY;
        `BST_OP_IDCODE: dr_sel = `BST_SEL_IDENT;
        `BST_OP_HIGHZ: dr_sel = `BST_SEL_BYPASS;
        `BST_OP_CLAMP: dr_sel = `BST_SEL_BYPASS;
        default: dr_sel = `BST_SEL_BYPASS;
      endcase
    end
  endfunction

  // instructions that put the update cells onto the pads
  function drives_pins;
    input [`BST_IR_W-1:0] ir;
    begin
      drives_pins = (ir == `BST_OP_EXTEST) || (ir == `BST_OP_CLAMP);
    end
  endfunction

  // controller next state from tms
  function [3:0] tap_next;
    input [3:0] s;
    input tms;
    begin
      case (s)
        `BST_ST_RESET: tap_next = tms ? `BST_ST_RESET : `BST_ST_IDLE;
        `BST_ST_IDLE: tap_next = tms ? `BST_ST_SEL_DR : `BST_ST_IDLE;
        `BST_ST_SEL_DR: tap_next = tms ? `BST_ST_SEL_IR : `BST_ST_CAP_DR;
        `BST_ST_CAP_DR: tap_next = tms ? `BST_ST_EX1_DR : `BST_ST_SH_DR;
        `BST_ST_SH_DR: tap_next = tms ? `BST_ST_EX1_DR : `BST_ST_SH_DR;
        `BST_ST_EX1_DR: tap_next = tms ? `BST_ST_UPD_DR : `BST_ST_PAU_DR;
        `BST_ST_PAU_DR: tap_next = tms ? `BST_ST_EX2_DR : `BST_ST_PAU_DR;
        `BST_ST_EX2_DR: tap_next = tms ? `BST_ST_UPD_DR : `BST_ST_SH_DR;
        `BST_ST_UPD_DR: tap_next = tms ? `BST_ST_SEL_DR : `BST_ST_IDLE;
        `BST_ST_SEL_IR: tap_next = tms ? `BST_ST_RESET : `BST_ST_CAP_IR;
        `BST_ST_CAP_IR: tap_next = tms ? `BST_ST_EX1_IR : `BST_ST_SH_IR;
        `BST_ST_SH_IR: tap_next = tms ? `BST_ST_EX1_IR : `BST_ST_SH_IR;
        `BST_ST_EX1_IR: tap_next = tms ? `BST_ST_UPD_IR : `BST_ST_PAU_IR;
        `BST_ST_PAU_IR: tap_next = tms ? `BST_ST_EX2_IR : `BST_ST_PAU_IR;
        `BST_ST_EX2_IR: tap_next = tms ? `BST_ST_UPD_IR : `BST_ST_SH_IR;
        `BST_ST_UPD_IR: tap_next = tms ? `BST_ST_SEL_DR : `BST_ST_IDLE;
        default: tap_next = `BST_ST_RESET;
      endcase
    end
  endfunction

  // ****************************************************************
  // reset merge and pin synchronisers
  // ****************************************************************
  reg [1:0] rst_sync_q; // test reset: asserts at once, releases synchronously
  reg [2:0] tck_q; // stages 0,1 synchronise, stage 2 finds edges
  reg [1:0] tms_q; // synchroniser
  reg [1:0] tdi_q; // synchroniser
  reg [NUM_IN-1:0] in_s1_q; // input pad first stage
  reg [NUM_IN-1:0] in_s2_q; // input pad second stage
  reg [NUM_IO-1:0] io_s1_q; // bidir pad first stage
  reg [NUM_IO-1:0] io_s2_q; // bidir pad second stage
  wire tap_rst_n = rst_n_i & trst_n_i; // power-on or test reset pin
  wire tap_rst_ok = rst_sync_q[1];
  wire tck_rise = tck_q[1] & ~tck_q[2];
  wire tck_fall = ~tck_q[1] & tck_q[2];

  // release is aligned to the system clock so no flop sees a runt
  always @(posedge sys_clk_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // two flops on every pin except the test reset before any logic looks at it
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tck_q <= 3'h0;
      tms_q <= 2'h3;
      tdi_q <= 2'h3;
      in_s1_q <= {NUM_IN{1'b0}};
      in_s2_q <= {NUM_IN{1'b0}};
      io_s1_q <= {NUM_IO{1'b0}};
      io_s2_q <= {NUM_IO{1'b0}};
    end else begin
      tck_q <= {tck_q[1:0], tck_i};
      tms_q <= {tms_q[0], tms_i};
      tdi_q <= {tdi_q[0], tdi_i};
      in_s1_q <= pad_in_i;
      in_s2_q <= in_s1_q;
      io_s1_q <= pad_io_i;
      io_s2_q <= io_s1_q;
    end
  end

  // core always sees the real pads; scan cells only observe them
  assign core_in_o = in_s2_q;
  assign core_io_in_o = io_s2_q;

  // ****************************************************************
  // controller, instruction and data registers
  // ****************************************************************
  reg [3:0] state_q; // controller state
  reg [`BST_IR_W-1:0] ir_sh_q; // instruction shift stage
  reg [`BST_IR_W-1:0] ir_q; // active instruction
  reg byp_q; // bypass stage
  reg [`BST_ID_W-1:0] id_sh_q; // identification shift stage
  reg [CHAIN-1:0] bsr_sh_q; // boundary shift cells
  reg [CHAIN-1:0] bsr_up_q; // boundary update cells
  wire [CHAIN-1:0] bsr_cap; // parallel capture values
  wire [1:0] sel = dr_sel(ir_q);
  wire fifo_in_ready;
  wire shifting = (state_q == `BST_ST_SH_DR) || (state_q == `BST_ST_SH_IR);
  reg out_bit; // chain end feeding the output buffer
  reg [NUM_OUT-1:0] pad_out_q; // output pad level
  reg [NUM_OUT-1:0] pad_out_oe_q; // output pad enable
  reg [NUM_IO-1:0] pad_io_q; // bidir pad level
  reg [NUM_IO-1:0] pad_io_oe_q; // bidir pad enable, also captured by control cells

  // cell kinds by position in the chain
  genvar g;
  generate
    for (g = 0; g < NUM_IN; g = g + 1) begin : g_in_cell
      assign bsr_cap[g] = in_s2_q[g];
    end
    for (g = 0; g < NUM_OUT; g = g + 1) begin : g_out_cell
      assign bsr_cap[OFS_OUT+g] = pad_out_q[g];
    end
    for (g = 0; g < NUM_IO; g = g + 1) begin : g_io_cell
      assign bsr_cap[OFS_IO+g] = io_s2_q[g];
      assign bsr_cap[OFS_CTL+g] = pad_io_oe_q[g];
    end
  endgenerate

  // least significant stage of the selected path leaves first
  always @* begin
    out_bit = byp_q;
    if (state_q == `BST_ST_SH_IR) begin
      out_bit = ir_sh_q[0];
    end else if (sel == `BST_SEL_BOUNDARY) begin
      out_bit = bsr_sh_q[0];
    end else if (sel == `BST_SEL_IDENT) begin
      out_bit = id_sh_q[0];
    end
  end

  // all work is done on rising test clock edges; a rising edge that meets a full
  // output buffer is skipped, and a bit queued while the buffer is full is dropped
  always @(posedge sys_clk_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      state_q <= `BST_ST_RESET;
      ir_sh_q <= `BST_IR_CAPTURE;
      ir_q <= `BST_OP_IDCODE;
      byp_q <= 1'b0;
      id_sh_q <= {`BST_ID_W{1'b0}};
      bsr_sh_q <= {CHAIN{1'b0}};
      bsr_up_q <= {CHAIN{1'b0}};
    end else if (!tap_rst_ok) begin
      state_q <= `BST_ST_RESET;
      ir_q <= `BST_OP_IDCODE;
    end else if (tck_rise && fifo_in_ready) begin
      state_q <= tap_next(state_q, tms_q[1]);
      case (state_q)
        `BST_ST_RESET: begin
          ir_q <= `BST_OP_IDCODE;
        end
        `BST_ST_CAP_IR: begin
          ir_sh_q <= `BST_IR_CAPTURE;
        end
        `BST_ST_SH_IR: begin
          ir_sh_q <= {tdi_q[1], ir_sh_q[`BST_IR_W-1:1]};
        end
        `BST_ST_UPD_IR: begin
          ir_q <= ir_sh_q;
        end
        `BST_ST_CAP_DR: begin
          byp_q <= 1'b0;
          id_sh_q <= ID_VALUE;
          if (sel == `BST_SEL_BOUNDARY) begin
            bsr_sh_q <= bsr_cap;
          end
        end
        `BST_ST_SH_DR: begin
          byp_q <= tdi_q[1];
          id_sh_q <= {tdi_q[1], id_sh_q[`BST_ID_W-1:1]};
          if (sel == `BST_SEL_BOUNDARY) begin
            bsr_sh_q <= {tdi_q[1], bsr_sh_q[CHAIN-1:1]};
          end
        end
        `BST_ST_UPD_DR: begin
          if (sel == `BST_SEL_BOUNDARY) begin
            bsr_up_q <= bsr_sh_q;
          end
        end
        default: begin
          byp_q <= byp_q;
        end
      endcase
    end
  end

  // ****************************************************************
  // pad drivers
  // ****************************************************************
  // pad registers are declared with the chain, whose capture reads them

  // sample leaves the core in charge; extest and clamp hand pads to
  // the update cells; highz floats everything except the test output
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pad_out_q <= {NUM_OUT{1'b0}};
      pad_out_oe_q <= {NUM_OUT{1'b0}};
      pad_io_q <= {NUM_IO{1'b0}};
      pad_io_oe_q <= {NUM_IO{1'b0}};
    end else if (ir_q == `BST_OP_HIGHZ) begin
      pad_out_q <= core_out_i;
      pad_out_oe_q <= {NUM_OUT{1'b0}};
      pad_io_q <= core_io_out_i;
      pad_io_oe_q <= {NUM_IO{1'b0}};
    end else if (drives_pins(ir_q)) begin
      pad_out_q <= bsr_up_q[OFS_OUT +: NUM_OUT];
      pad_out_oe_q <= {NUM_OUT{1'b1}};
      pad_io_q <= bsr_up_q[OFS_IO +: NUM_IO];
      pad_io_oe_q <= bsr_up_q[OFS_CTL +: NUM_IO];
    end else begin
      pad_out_q <= core_out_i;
      pad_out_oe_q <= {NUM_OUT{1'b1}};
      pad_io_q <= core_io_out_i;
      pad_io_oe_q <= core_io_oe_i;
    end
  end

  assign pad_out_o = pad_out_q;
  assign pad_out_oe_o = pad_out_oe_q;
  assign pad_io_o = pad_io_q;
  assign pad_io_oe_o = pad_io_oe_q;

  // ****************************************************************
  // serial output path
  // ****************************************************************
  reg tdo_q; // test output level
  reg tdo_oe_q; // test output enable
  wire fifo_out_valid;
  wire fifo_out_bit;
  wire push = tck_fall & shifting & tap_rst_ok;
  wire drain = ~tck_q[1]; // only while the test clock is low

  // the bit for the next rising edge is queued at the falling edge
  bst_fifo #(
    .WIDTH(1),
    .DEPTH(`BST_FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(out_bit),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(drain),
    .out_data_o(fifo_out_bit)
  );

  // output level follows the buffer in the low phase; enable tracks
  // the shift states at each falling edge
  always @(posedge sys_clk_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      if (fifo_out_valid && drain) begin
        tdo_q <= fifo_out_bit;
      end
      if (!tap_rst_ok) begin
        tdo_oe_q <= 1'b0;
      end else if (tck_fall) begin
        tdo_oe_q <= shifting;
      end
    end
  end

  assign tdo_o = tdo_q;
  assign tdo_oe_o = tdo_oe_q;
  assign tap_state_o = state_q;
  assign instr_o = ir_q;
endmodule // bst_tap

`default_nettype wire

// >>> tb/bst_tap_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "bst_defs.vh"
// ********
// bench top
// ********
module bst_tap_bench;
  localparam int NI = 3;
  localparam int NO = 2;
  localparam int NIO = 4;
  localparam int CL = NI + NO + 2 * NIO; // chain length
  localparam logic [3:0] VER = 4'h6; // arbitrary value
  localparam logic [15:0] PART = 16'hc3e1; // arbitrary value
  localparam logic [10:0] MFR = 11'h155; // arbitrary value
  localparam logic [CL-1:0] PRE = 13'h1a5b; // preload pattern
  // clock, reset and test pins
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe;
  // core and pad side
  logic [NO-1:0] core_out_i = 2'h2;
  logic [NIO-1:0] core_io_out_i = 4'h3;
  logic [NIO-1:0] core_io_oe_i = 4'h6;
  logic [NI-1:0] pad_in_i = 3'h5;
  logic [NIO-1:0] pad_io_i = 4'ha;
  logic [NI-1:0] core_in_o;
  logic [NIO-1:0] core_io_in_o, pad_io_o, pad_io_oe_o;
  logic [NO-1:0] pad_out_o, pad_out_oe_o;
  logic [3:0] tap_state_o;
  logic [4:0] instr_o;
  logic [4:0] codes [0:5] = '{`BST_OP_CLAMP, `BST_OP_HIGHZ, `BST_OP_BYPASS, 5'h02, 5'h09, 5'h0a};
  int fails = 0;
  int checked = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  bst_tap #(.NUM_IN(NI), .NUM_OUT(NO), .NUM_IO(NIO), .ID_VERSION(VER), .ID_PART(PART),
    .ID_MFR(MFR)) uut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .core_out_i(core_out_i),
    .core_io_out_i(core_io_out_i), .core_io_oe_i(core_io_oe_i), .core_in_o(core_in_o),
    .core_io_in_o(core_io_in_o), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
    .pad_out_oe_o(pad_out_oe_o), .pad_io_i(pad_io_i), .pad_io_o(pad_io_o),
    .pad_io_oe_o(pad_io_oe_o), .tap_state_o(tap_state_o), .instr_o(instr_o));

  bst_tester u_tst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n),
    .tdo_i(tdo), .tdo_oe_i(tdo_oe));

  // one compare for every result; unknowns never match
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // load an instruction; the shifted-out value is the capture pattern
  task automatic load_ir(input logic [4:0] code);
    logic [31:0] d;
    logic ok;
    u_tst.scan(1'b1, 5, {27'h0, code}, d, ok);
    check("ir capture", 32'h01, d);
    check("tdo enable ir", 32'h1, ok);
    repeat (2) @(posedge sys_clk_i);
  endtask

  // data scan, tdo must be driven for every bit
  task automatic dr(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic ok;
    u_tst.scan(1'b0, n, din, dout, ok);
    check("tdo enable dr", 32'h1, ok);
  endtask

  // verdict, reached from the main sequence or the watchdog
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // the sequence needs about 40 us; five times that, well under the cycle budget
  initial begin
    #200000;
    fails++;
    $display("BAD watchdog expected finish seen hang");
    complete_run();
  end

  initial begin
    logic [31:0] d;
    int k;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    check("reset state", `BST_ST_RESET, tap_state_o);
    check("reset instr", `BST_OP_IDCODE, instr_o);
    check("idle tdo enable", 32'h0, tdo_oe);
    check("core inputs", {pad_io_i, pad_in_i}, {core_io_in_o, core_in_o});
    u_tst.to_idle();
    check("idle state", `BST_ST_IDLE, tap_state_o);
    dr(32, 32'hffffffff, d);
    check("identification", {VER, PART, MFR, 1'b1}, d);
    $display("test identification done");
    // sample: capture pins, preload cells, core keeps the pads
    load_ir(`BST_OP_SAMPLE);
    dr(CL, PRE, d);
    check("sample capture", {4'h6, 4'ha, 2'h2, 3'h5}, d);
    check("sample pads", {4'h6, 4'h3, 2'h3, 2'h2},
      {pad_io_oe_o, pad_io_o, pad_out_oe_o, pad_out_o});
    // extest: pads from the preloaded cells, capture the new pin levels
    load_ir(`BST_OP_EXTEST);
    check("extest pads", {PRE[12:9], PRE[8:5], 2'h3, PRE[4:3]},
      {pad_io_oe_o, pad_io_o, pad_out_oe_o, pad_out_o});
    @(posedge sys_clk_i);
    pad_in_i <= 3'h2;
    pad_io_i <= 4'h9;
    repeat (4) @(posedge sys_clk_i);
    dr(CL, PRE, d);
    check("extest capture", {PRE[12:9], 4'h9, PRE[4:3], 3'h2}, d);
    $display("test boundary done");
    // bypass-type codes, undefined ones included
    for (k = 0; k < 6; k++) begin
      load_ir(codes[k]);
      dr(8, 32'h96, d);
      check("bypass path", 32'h2c, d);
      if (codes[k] == `BST_OP_CLAMP) begin
        check("clamp pads", {PRE[12:9], PRE[8:5], PRE[4:3]},
          {pad_io_oe_o, pad_io_o, pad_out_o});
      end
      if (codes[k] == `BST_OP_HIGHZ) begin
        check("highz enables", 32'h0, {pad_out_oe_o, pad_io_oe_o});
      end
    end
    $display("test bypass done");
    // pin reset from a non-default instruction
    u_tst.trst_pulse();
    check("trst state", `BST_ST_RESET, tap_state_o);
    check("trst instr", `BST_OP_IDCODE, instr_o);
    u_tst.to_idle();
    dr(32, 32'h0, d);
    check("identification again", {VER, PART, MFR, 1'b1}, d);
    $display("test reset pin done");
    complete_run();
  end
endmodule // bst_tap_bench
`default_nettype wire

// >>> tb/bst_tap_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "bst_defs.vh"
// ********
// tap checker, sees the top ports only
// ********
module bst_tap_properties #(
  parameter NUM_OUT = 2,
  parameter NUM_IO = 4
) (
  // clock and resets
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic trst_n_i,
  // test port
  input wire logic tck_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_o,
  // core side
  input wire logic [NUM_OUT-1:0] core_out_i,
  input wire logic [NUM_IO-1:0] core_io_out_i,
  input wire logic [NUM_IO-1:0] core_io_oe_i,
  // pad side
  input wire logic [NUM_OUT-1:0] pad_out_o,
  input wire logic [NUM_OUT-1:0] pad_out_oe_o,
  input wire logic [NUM_IO-1:0] pad_io_o,
  input wire logic [NUM_IO-1:0] pad_io_oe_o,
  // status
  input wire logic [3:0] tap_state_o,
  input wire logic [`BST_IR_W-1:0] instr_o
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // test reset pin wins over any walk in progress
  property p_trst;
    !trst_n_i |-> tap_state_o == `BST_ST_RESET && instr_o == `BST_OP_IDCODE;
  endproperty
  a_trst: assert property (p_trst) else $error("test reset did not park the tap");
  // leaving reset can only go to idle
  property p_leave_reset;
    $changed(tap_state_o) && $past(tap_state_o) == `BST_ST_RESET |-> tap_state_o == `BST_ST_IDLE;
  endproperty
  a_leave_reset: assert property (p_leave_reset) else $error("bad step out of reset");
  // shift-dr only leaves through exit1 (or test reset)
  property p_leave_shdr;
    $changed(tap_state_o) && $past(tap_state_o) == `BST_ST_SH_DR
      |-> tap_state_o inside {`BST_ST_EX1_DR, `BST_ST_RESET};
  endproperty
  a_leave_shdr: assert property (p_leave_shdr) else $error("bad step out of shift dr");
  // update-ir goes on to idle or select-dr
  property p_leave_updir;
    $changed(tap_state_o) && $past(tap_state_o) == `BST_ST_UPD_IR
      |-> tap_state_o inside {`BST_ST_IDLE, `BST_ST_SEL_DR, `BST_ST_RESET};
  endproperty
  a_leave_updir: assert property (p_leave_updir) else $error("bad step out of update ir");
  // the instruction only moves around update-ir or in reset
  property p_instr_upd;
    $changed(instr_o)
      |-> $past(tap_state_o) == `BST_ST_UPD_IR || tap_state_o inside {`BST_ST_UPD_IR, `BST_ST_RESET};
  endproperty
  a_instr_upd: assert property (p_instr_upd) else $error("instruction moved outside update");
  // highz floats every pad enable
  property p_highz;
    $past(instr_o) == `BST_OP_HIGHZ && instr_o == `BST_OP_HIGHZ
      |-> pad_out_oe_o == '0 && pad_io_oe_o == '0;
  endproperty
  a_highz: assert property (p_highz) else $error("pad driven under highz");
  // extest always drives the output pads
  property p_extest;
    $past(instr_o) == `BST_OP_EXTEST && instr_o == `BST_OP_EXTEST |-> &pad_out_oe_o;
  endproperty
  a_extest: assert property (p_extest) else $error("output pad floats under extest");
  // sample leaves the core in charge of the pads, one register late
  property p_sample;
    $past(instr_o) == `BST_OP_SAMPLE && instr_o == `BST_OP_SAMPLE
      |-> pad_out_o == $past(core_out_i) && pad_io_o == $past(core_io_out_i)
          && pad_io_oe_o == $past(core_io_oe_i) && &pad_out_oe_o;
  endproperty
  a_sample: assert property (p_sample) else $error("sample disturbed the pads");
  // serial output is released in idle and in reset
  property p_oe_idle;
    tap_state_o inside {`BST_ST_IDLE, `BST_ST_RESET} |-> !tdo_oe_o;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("serial output driven while idle");
  // serial output only moves in the low phase of the test clock
  property p_tdo_low;
    $changed(tdo_o) && trst_n_i && $past(trst_n_i) |-> !tck_i;
  endproperty
  a_tdo_low: assert property (p_tdo_low) else $error("serial output moved with clock high");
endmodule // bst_tap_properties

bind bst_tap bst_tap_properties #(.NUM_OUT(NUM_OUT), .NUM_IO(NUM_IO)) u_props (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .trst_n_i(trst_n_i), .tck_i(tck_i),
  .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .core_out_i(core_out_i),
  .core_io_out_i(core_io_out_i), .core_io_oe_i(core_io_oe_i), .pad_out_o(pad_out_o),
  .pad_out_oe_o(pad_out_oe_o), .pad_io_o(pad_io_o), .pad_io_oe_o(pad_io_oe_o),
  .tap_state_o(tap_state_o), .instr_o(instr_o));
`default_nettype wire

// >>> tb/bst_tester.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// boundary scan tester model
// ********
module bst_tester (
  // test port drive
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_n_o,
  // test port sense
  input wire logic tdo_i,
  input wire logic tdo_oe_i
);
  localparam realtime HALF = 62.5; // half of the 125 ns test clock
  logic tdo_line; // pulled up while the device lets go
  assign tdo_line = tdo_oe_i ? tdo_i : 1'b1;

  // clock stands still low between frames
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    trst_n_o = 1'b1;
  end

  // one clock period; mode and data change only in the low phase
  task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe);
    // nonblocking, so a change that lands on a system clock edge cannot race it
    tms_o <= tms;
    tdi_o <= tdi;
    #HALF;
    tdo = tdo_line; // taken just before the rising edge
    oe = tdo_oe_i;
    tck_o <= 1'b1;
    #HALF;
    tck_o <= 1'b0;
  endtask

  // five ones reach reset from anywhere, a zero parks in idle
  task automatic to_idle;
    logic t;
    logic e;
    repeat (5) step(1'b1, 1'b0, t, e);
    step(1'b0, 1'b0, t, e);
  endtask

  // pin reset, held well over one system clock
  task automatic trst_pulse;
    trst_n_o <= 1'b0;
    #100;
    trst_n_o <= 1'b1;
    #100;
  endtask

  // idle to idle scan of ir or dr, lsb first; also reports whether tdo was driven
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output logic oe_ok);
    logic t;
    logic e;
    int i;
    dout = '0;
    oe_ok = 1'b1;
    step(1'b1, 1'b0, t, e);
    if (ir) step(1'b1, 1'b0, t, e);
    step(1'b0, 1'b0, t, e);
    step(1'b0, 1'b0, t, e);
    for (i = 0; i < n; i++) begin
      step(i == n - 1, din[i], t, e);
      dout[i] = t;
      oe_ok = oe_ok & e;
    end
    step(1'b1, 1'b0, t, e);
    step(1'b0, 1'b0, t, e);
  endtask
endmodule // bst_tester
`default_nettype wire
